// ===== sgan_pkg.sv
/*
  constants for the serial gigabit port auto-negotiation control and status bank:
  register indices, field positions, codes and reset values.
  assumes a 32-bit apb slave where byte address = 4 * register index.
*/
package sgan_pkg;
  // register indices; byte address is four times the index
  localparam logic [20:0] CTRL_INDEX = 21'h1F8001;
  localparam logic [20:0] STAT_INDEX = 21'h1F8002;
  localparam logic [20:0] ADV_INDEX = 21'h1F8003;
  localparam int unsigned INDEX_W = 21;
  localparam int unsigned REG_W = 16;
  localparam int unsigned USED_W = 5;

  // control field positions
  localparam int unsigned CTRL_IRQ_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_ROLE_BIT = 3;
  localparam int unsigned CTRL_LINK_BIT = 4;

  // status field positions
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned STAT_DUPLEX_BIT = 1;
  localparam int unsigned STAT_SPEED_LSB = 2;
  localparam int unsigned STAT_LINK_BIT = 4;

  // pcs mode codes; 01 and 11 are reserved
  localparam logic [1:0] MODE_SERDES = 2'h0;
  localparam logic [1:0] MODE_SGMII = 2'h2;

  // partner speed codes; 11 is reserved
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h04;
  localparam logic [15:0] ADV_RESET = 16'h0000;
  localparam logic [1:0] SPEED_RESET = 2'h0;
endpackage

// ===== sgan_reg_if.sv
/*
  carrier between the apb front end and the register bank.
  assumes selects and write data are stable for the whole transfer.
*/
`timescale 1ns/1ps
interface sgan_reg_if;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_adv;
  logic wr_fire;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport front (output sel_ctrl, output sel_stat, output sel_adv, output wr_fire, output wdata, input rdata);
  modport regs (input sel_ctrl, input sel_stat, input sel_adv, input wr_fire, input wdata, output rdata);
endinterface

// ===== sgan_apb_front.sv
/*
  apb slave front end: address decode, no-wait-state answer, error on unmapped address.
  assumes an apb master that holds the request until pready is seen high.
*/
`timescale 1ns/1ps
module sgan_apb_front #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // write when high
  input wire logic [ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic pready, // transfer done
  output logic [31:0] prdata, // read data
  output logic pslverr, // unmapped address
  sgan_reg_if.front regs // to the register bank
);
  initial begin
    if (ADDR_W < sgan_pkg::INDEX_W + 2) begin
      $error("ADDR_W too small for the register indices");
    end
  end

  wire [ADDR_W-3:0] index;
  wire aligned;
  wire mapped;
  wire setup;
  wire fire;

  // decode by word index; byte lanes below a word must be zero
  assign index = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign regs.sel_ctrl = aligned && (index == (ADDR_W-2)'(sgan_pkg::CTRL_INDEX));
  assign regs.sel_stat = aligned && (index == (ADDR_W-2)'(sgan_pkg::STAT_INDEX));
  assign regs.sel_adv = aligned && (index == (ADDR_W-2)'(sgan_pkg::ADV_INDEX));
  assign mapped = regs.sel_ctrl | regs.sel_stat | regs.sel_adv;
  assign setup = psel & ~penable;
  assign fire = psel & penable & pready;
  // unmapped writes are dropped here so the bank never sees them
  assign regs.wr_fire = fire & pwrite & mapped;
  assign regs.wdata = pwdata[15:0];

  // answer is registered: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= (pwrite || !mapped) ? 32'h00000000 : {16'h0000, regs.rdata};
      end
    end
  end
endmodule

// ===== sgan_ctrl_status.sv
/*
  auto-negotiation control and status bank of the serial gigabit port pcs.
  assumes pcs result inputs synchronous to pclk and an_done a one-cycle pulse.
*/
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - control writes wait; they apply when the advertisement register is written
// - control bit 3 picks role: 0 mac side, 1 phy side
// - bits 2:1 pick mode: 00 serdes, 10 sgmii, reset to sgmii
// - control bit 0 gates the completion interrupt output
// - status bit 4 shows partner link state, sgmii only
// - status bits 3:2 show partner speed, sgmii only
// - status bit 1 shows partner duplex, sgmii only
// - status bit 0 sets on completion, cleared by writing zero
// - completion flag ignores the interrupt enable
// - in serdes mode link, speed and duplex fields carry no result
module sgan_ctrl_status #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic pcs_an_done, // negotiation finished, pulse
  input wire logic pcs_partner_link, // link reported by partner
  input wire logic [1:0] pcs_partner_speed, // speed reported by partner
  input wire logic pcs_partner_duplex, // duplex reported by partner
  output logic cfg_adv_link, // advertised link flag
  output logic cfg_phy_side, // 1 phy side, 0 mac side
  output logic [1:0] cfg_pcs_mode, // applied pcs mode
  output logic an_irq // completion interrupt
);
  sgan_reg_if bus ();

  sgan_apb_front #(.ADDR_W(ADDR_W)) front (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .regs(bus.front)
  );

  logic [4:0] ctrl_pend;
  logic [4:0] ctrl_act;
  logic [15:0] advert;
  logic part_link;
  logic [1:0] part_speed;
  logic part_duplex;
  logic an_done_flag;

  wire wr_ctrl;
  wire wr_stat;
  wire wr_adv;
  wire [1:0] wr_mode;
  wire mode_legal;
  wire [4:0] next_ctrl_pend;
  wire act_sgmii;
  wire clear_done;
  wire next_done;
  wire [4:0] stat_view;

  // write strobes per register
  assign wr_ctrl = bus.wr_fire & bus.sel_ctrl;
  assign wr_stat = bus.wr_fire & bus.sel_stat;
  assign wr_adv = bus.wr_fire & bus.sel_adv;

  // a reserved mode code is not taken; the field keeps its last legal value
  assign wr_mode = bus.wdata[sgan_pkg::CTRL_MODE_LSB +: 2];
  assign mode_legal = (wr_mode == sgan_pkg::MODE_SERDES) || (wr_mode == sgan_pkg::MODE_SGMII);
  assign next_ctrl_pend = {bus.wdata[sgan_pkg::CTRL_LINK_BIT], bus.wdata[sgan_pkg::CTRL_ROLE_BIT],
                           mode_legal ? wr_mode : ctrl_pend[sgan_pkg::CTRL_MODE_LSB +: 2],
                           bus.wdata[sgan_pkg::CTRL_IRQ_EN_BIT]};

  // held control copy; software reads back the fields it wrote, except that a reserved mode code is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_pend <= sgan_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_pend <= next_ctrl_pend;
    end
  end

  // applied copy moves only on an advertisement write, so mode and role change together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_act <= sgan_pkg::CTRL_RESET;
      advert <= sgan_pkg::ADV_RESET;
    end else if (wr_adv) begin
      ctrl_act <= ctrl_pend;
      advert <= bus.wdata;
    end
  end

  // partner results are kept only while the applied mode is sgmii
  assign act_sgmii = (ctrl_act[sgan_pkg::CTRL_MODE_LSB +: 2] == sgan_pkg::MODE_SGMII);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_link <= 1'b0;
      part_speed <= sgan_pkg::SPEED_RESET;
      part_duplex <= 1'b0;
    end else begin
      part_link <= act_sgmii & pcs_partner_link;
      part_speed <= act_sgmii ? pcs_partner_speed : sgan_pkg::SPEED_RESET;
      part_duplex <= act_sgmii & pcs_partner_duplex;
    end
  end

  // sticky completion flag; a set in the clearing cycle wins so no event is lost
  assign clear_done = wr_stat & ~bus.wdata[sgan_pkg::STAT_DONE_BIT];
  assign next_done = pcs_an_done | (an_done_flag & ~clear_done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_done_flag <= 1'b0;
    end else begin
      an_done_flag <= next_done;
    end
  end

  // configuration outputs follow the applied copy, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_adv_link <= 1'b0;
      cfg_phy_side <= 1'b0;
      cfg_pcs_mode <= sgan_pkg::MODE_SGMII;
      an_irq <= 1'b0;
    end else begin
      cfg_adv_link <= ctrl_act[sgan_pkg::CTRL_LINK_BIT];
      cfg_phy_side <= ctrl_act[sgan_pkg::CTRL_ROLE_BIT];
      cfg_pcs_mode <= ctrl_act[sgan_pkg::CTRL_MODE_LSB +: 2];
      an_irq <= next_done & ctrl_act[sgan_pkg::CTRL_IRQ_EN_BIT];
    end
  end

  // read mux; upper bits of control and status are always zero
  assign stat_view = {part_link, part_speed, part_duplex, an_done_flag};
  assign bus.rdata = bus.sel_ctrl ? {11'h000, ctrl_pend} :
                     bus.sel_stat ? {11'h000, stat_view} :
                     bus.sel_adv ? advert : 16'h0000;
endmodule

// ===== sgan_ctrl_status_assertions.sv
/* checker for the auto-negotiation bank: answer timing, held control, status and irq.
   assumes it is bound to the bank's top ports. */
`timescale 1ns/1ps
module sgan_chk #(parameter int unsigned ADDR_W = 24) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [ADDR_W-1:0] paddr, // address
  input wire logic pready, // ready
  input wire logic [31:0] prdata, // rdata
  input wire logic pslverr, // error
  input wire logic pcs_an_done, // done
  input wire logic pcs_partner_link, // link
  input wire logic [1:0] pcs_partner_speed, // speed
  input wire logic pcs_partner_duplex, // duplex
  input wire logic cfg_phy_side, // role
  input wire logic [1:0] cfg_pcs_mode, // mode
  input wire logic an_irq // irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded bus events
  wire wr = psel && penable && pready && pwrite;
  wire rs = psel && !penable && !pwrite;
  wire st = paddr == ADDR_W'({sgan_pkg::STAT_INDEX, 2'h0});
  wire ct = paddr == ADDR_W'({sgan_pkg::CTRL_INDEX, 2'h0});
  wire wa = wr && paddr == ADDR_W'({sgan_pkg::ADV_INDEX, 2'h0});
  wire ws = wr && st;
  wire [3:0] pr = {pcs_partner_link, pcs_partner_speed, pcs_partner_duplex};
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_apply; $changed({cfg_phy_side, cfg_pcs_mode}) |-> $past(wa, 2); endproperty
  a_apply: assert property (p_apply) else $error("config moved without advert write");
  property p_mode; cfg_pcs_mode[0] == 1'h0; endproperty
  a_mode: assert property (p_mode) else $error("reserved mode applied");
  property p_rise; $rose(an_irq) |-> $past(pcs_an_done) || $past(wa) || $past(wa, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
  property p_fall; $fell(an_irq) |-> $past(ws) || $past(wa) || $past(wa, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without write");
  property p_resv; rs && (ct || st) |=> prdata[31:5] == 27'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_fields; rs && st && cfg_pcs_mode == sgan_pkg::MODE_SGMII |=> prdata[4:1] == $past(pr, 2); endproperty
  a_fields: assert property (p_fields) else $error("partner fields wrong");
  property p_serdes; rs && st && cfg_pcs_mode == sgan_pkg::MODE_SERDES |=> prdata[4:1] == 4'h0; endproperty
  a_serdes: assert property (p_serdes) else $error("fields shown in serdes");
  // main scenarios reached
  c_irq: cover property ($rose(an_irq));
  c_err: cover property (pready && pslverr);
  c_apply: cover property ($changed(cfg_pcs_mode));
endmodule

// ===== sgan_pcs_model.sv
/* partner model: a link peer that announces its result after a set delay.
   assumes one negotiation at a time and a delay of at least one cycle. */
`timescale 1ns/1ps
module sgan_pcs_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic start, // begin negotiation
  input wire logic [7:0] lat, // cycles to done
  input wire logic [3:0] res, // link, speed, duplex
  output logic pcs_an_done, // completion pulse
  output logic pcs_partner_link, // announced link
  output logic [1:0] pcs_partner_speed, // announced speed
  output logic pcs_partner_duplex // announced duplex
);
  logic [7:0] cnt;
  // result lands with the pulse, so a later read sees it settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      pcs_an_done <= 1'h0;
      {pcs_partner_link, pcs_partner_speed, pcs_partner_duplex} <= 4'h0;
    end else begin
      pcs_an_done <= !start && cnt == 8'h01;
      cnt <= start ? lat : (cnt != 8'h00 ? cnt - 8'h01 : cnt);
      if (!start && cnt == 8'h01) begin
        {pcs_partner_link, pcs_partner_speed, pcs_partner_duplex} <= res;
      end
    end
  end
endmodule

// ===== sgan_ctrl_status_tb.sv
/* bench for the auto-negotiation bank with a partner model.
   assumes one apb answer per transfer and a 100 MHz clock. */
`timescale 1ns/1ps
module sgan_ctrl_status_tb;
  localparam logic [23:0] A_CTL = {1'h0, sgan_pkg::CTRL_INDEX, 2'h0};
  localparam logic [23:0] A_ST = {1'h0, sgan_pkg::STAT_INDEX, 2'h0};
  localparam logic [23:0] A_ADV = {1'h0, sgan_pkg::ADV_INDEX, 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, start = 1'h0;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] lat = 8'h01;
  logic [3:0] res = 4'h0;
  logic pready, pslverr, err, pcs_an_done, pcs_partner_link, pcs_partner_duplex;
  logic cfg_adv_link, cfg_phy_side, an_irq;
  logic [1:0] pcs_partner_speed, cfg_pcs_mode;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  sgan_ctrl_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .pcs_an_done, .pcs_partner_link, .pcs_partner_speed, .pcs_partner_duplex,
    .cfg_adv_link, .cfg_phy_side, .cfg_pcs_mode, .an_irq);
  sgan_pcs_model other (.pclk, .presetn, .start, .lat, .res, .pcs_an_done, .pcs_partner_link,
    .pcs_partner_speed, .pcs_partner_duplex);
  task end_of_test;
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  // one transfer; an idle cycle first keeps release and next setup apart
  task apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task t_reset;
    apb(1'h0, A_CTL, 32'h0);
    chk("ctrl", 32'h4, rd);
    chk("mode", 32'h2, cfg_pcs_mode);
    apb(1'h0, A_ST, 32'h0);
    chk("stat", 32'h0, rd);
  endtask
  // serdes, phy side, link flag and irq enable, reserved bits set too
  task t_held;
    apb(1'h1, A_CTL, 32'hFFF9);
    repeat (3) @(posedge pclk);
    chk("held", 32'h2, {cfg_adv_link, cfg_phy_side, cfg_pcs_mode});
    apb(1'h0, A_CTL, 32'h0);
    chk("ctrl", 32'h19, rd);
    apb(1'h1, A_ADV, 32'h0);
    repeat (2) @(posedge pclk);
    chk("applied", 32'hC, {cfg_adv_link, cfg_phy_side, cfg_pcs_mode});
  endtask
  task t_done(input logic [7:0] l, input logic [3:0] r, input logic [31:0] e, input logic ie);
    @(posedge pclk);
    {start, lat, res} <= {1'h1, l, r};
    @(posedge pclk);
    start <= 1'h0;
    do @(posedge pclk); while (pcs_an_done !== 1'h1);
    @(posedge pclk);
    chk("irq", ie, an_irq);
    apb(1'h0, A_ST, 32'h0);
    chk("stat", e, rd);
    apb(1'h1, A_ST, 32'hFFFF);
    apb(1'h0, A_ST, 32'h0);
    chk("stat kept", e, rd);
    apb(1'h1, A_ST, 32'hFFFE);
    @(posedge pclk);
    chk("irq clr", 32'h0, an_irq);
    apb(1'h0, A_ST, 32'h0);
    chk("stat clr", e & 32'h1E, rd);
  endtask
  // mac-side sgmii, then a reserved mode code that must not stick
  task t_sgmii;
    apb(1'h1, A_CTL, 32'h4);
    apb(1'h1, A_CTL, 32'h2);
    apb(1'h0, A_CTL, 32'h0);
    chk("ctrl", 32'h4, rd);
    apb(1'h1, A_ADV, 32'h0);
    repeat (2) @(posedge pclk);
    chk("sgmii", 32'h2, {cfg_adv_link, cfg_phy_side, cfg_pcs_mode});
    for (int s = 0; s < 3; s++) begin
      t_done(8'h28, {1'h1, 2'(s), s[0]}, {27'h0, 1'h1, 2'(s), s[0], 1'h1}, 1'h0);
    end
    // result is valid now, so software refreshes control; it stays held until the next advert write
    apb(1'h1, A_CTL, 32'h14);
    apb(1'h0, A_CTL, 32'h0);
    chk("ctrl upd", 32'h14, rd);
    chk("upd held", 32'h2, {cfg_adv_link, cfg_phy_side, cfg_pcs_mode});
    apb(1'h1, A_ADV, 32'h0);
    repeat (2) @(posedge pclk);
    chk("upd applied", 32'hA, {cfg_adv_link, cfg_phy_side, cfg_pcs_mode});
    apb(1'h0, 24'h0, 32'h0);
    chk("unmapped", 32'h1, err);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_held;
    t_done(8'h01, 4'hB, 32'h1, 1'h1);
    t_sgmii;
    end_of_test;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end
endmodule
bind sgan_ctrl_status sgan_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .prdata, .pslverr, .pcs_an_done, .pcs_partner_link, .pcs_partner_speed,
  .pcs_partner_duplex, .cfg_phy_side, .cfg_pcs_mode, .an_irq);
